// File: rtl/iuvl_pkg.sv
// Purpose: Shared constants for the input undervoltage lockout control block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Threshold reset value is unknown in hardware; zero is used here.
package iuvl_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] IUVL_THRESH_OFF = 8'h00;
  localparam logic [7:0] IUVL_STATUS_OFF = 8'h04;
  localparam logic [7:0] IUVL_MASK_OFF   = 8'h08;
  // ==========================================================================
  // Field layout of the threshold register
  localparam int         IUVL_EN_BIT     = 7;
  localparam int         IUVL_CODE_W     = 6;
  localparam logic [7:0] IUVL_THRESH_RST = 8'h00;
  localparam logic [7:0] IUVL_WR_MASK    = 8'hBF;
  // ==========================================================================
  // Status and mask layout
  localparam int         IUVL_ST_LOW_BIT  = 0;
  localparam int         IUVL_ST_FALL_BIT = 1;
  localparam logic [1:0] IUVL_ST_RST      = 2'h0;
  localparam logic [1:0] IUVL_MASK_RST    = 2'h0;
endpackage

// File: rtl/iuvl_ctrl.sv
// Purpose: Register, synchroniser and flag logic for input undervoltage lockout.
// Assumes: Comparator output is asynchronous; APB is synchronous to core_clk.
// Notes:   Unmapped reads return zero and unmapped writes are dropped.
`timescale 1ns/1ps

// What this block does
// - Six-bit lockout threshold code lives in bits 5..0, driving the DAC.
// - Bit 7 enables the lockout DAC; detection only works while it is set.
// - Bit 6 is unimplemented, reads zero, writes ignored.
// - Input-low flag sets while the comparator reports supply below threshold.
// - Input-low flag clears by itself once the supply rises above threshold.
// - The flag sets regardless of any interrupt enable.
module iuvl_ctrl
  import iuvl_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire logic                   supply_below_cmp,
  output logic                        lockout_enable,
  output logic [IUVL_CODE_W-1:0]      lockout_threshold_code,
  output logic                        input_low_flag,
  output logic                        irq
);

  // ==========================================================================
  // Types
  // One select bit per mapped register; all clear means an unmapped offset.
  typedef struct packed {
    logic thresh;
    logic status;
    logic mask;
  } iuvl_sel_t;

  typedef struct packed {
    logic [7:0]  thresh;
    logic        sync1;
    logic        sync2;
    logic        low;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [31:0] rdata;
    logic        ack_due;
  } iuvl_state_t;

  localparam iuvl_state_t STATE_RST = '{
    thresh  : IUVL_THRESH_RST,
    sync1   : 1'b0,
    sync2   : 1'b0,
    low     : 1'b0,
    status  : IUVL_ST_RST,
    mask    : IUVL_MASK_RST,
    rdata   : 32'h00000000,
    ack_due : 1'b0
  };

  // ==========================================================================
  // Helpers
  // The write path and the read path share one decode, so they cannot
  // disagree on which register an offset selects.
  function automatic iuvl_sel_t decode_addr(input logic [7:0] addr);
    iuvl_sel_t hit;
    hit        = '0;
    hit.thresh = (addr == IUVL_THRESH_OFF);
    hit.status = (addr == IUVL_STATUS_OFF);
    hit.mask   = (addr == IUVL_MASK_OFF);
    return hit;
  endfunction

  // Bit 6 has no storage, so it is dropped on write and on read alike.
  function automatic logic [7:0] keep_impl_bits(input logic [7:0] value);
    logic [7:0] kept;
    kept = value & IUVL_WR_MASK;
    return kept;
  endfunction

  function automatic logic enable_field(input logic [7:0] thresh);
    logic en;
    en = thresh[IUVL_EN_BIT];
    return en;
  endfunction

  function automatic logic [IUVL_CODE_W-1:0] code_field(input logic [7:0] thresh);
    logic [IUVL_CODE_W-1:0] code;
    code = thresh[IUVL_CODE_W-1:0];
    return code;
  endfunction

  function automatic logic [31:0] zext_byte(input logic [7:0] value);
    logic [31:0] word;
    word = {24'h000000, value};
    return word;
  endfunction

  function automatic logic [31:0] zext_pair(input logic [1:0] value);
    logic [31:0] word;
    word = {30'h0, value};
    return word;
  endfunction

  function automatic logic [31:0] read_word(input iuvl_sel_t   hit,
                                            input iuvl_state_t cur);
    logic [31:0] word;
    word = 32'h00000000;
    if (hit.thresh) begin
      word = zext_byte(keep_impl_bits(cur.thresh));
    end
    if (hit.status) begin
      word = zext_pair(cur.status);
    end
    if (hit.mask) begin
      word = zext_pair(cur.mask);
    end
    return word;
  endfunction

  // Lockout only counts while the enable bit is set, so a disabled block can
  // neither raise the flag nor log events.
  function automatic logic gate_low(input logic below, input logic [7:0] thresh);
    logic gated;
    gated = below & enable_field(thresh);
    return gated;
  endfunction

  function automatic logic [1:0] next_status(input logic [1:0] cur,
                                             input logic       clear,
                                             input logic       low,
                                             input logic       rise);
    logic [1:0] nxt;
    nxt = cur;
    if (clear) begin
      nxt = 2'h0;
    end
    // Set wins over the read clear, so an event in the clearing cycle stays.
    if (low) begin
      nxt[IUVL_ST_LOW_BIT] = 1'b1;
    end
    if (rise) begin
      nxt[IUVL_ST_FALL_BIT] = 1'b1;
    end
    return nxt;
  endfunction

  function automatic logic irq_level(input logic [1:0] status, input logic [1:0] mask);
    logic level;
    level = |(status & mask);
    return level;
  endfunction

  // ==========================================================================
  // Signals
  iuvl_state_t st_r;
  iuvl_state_t st_nxt;
  iuvl_sel_t   sel;
  logic        acc;
  logic        wr_take;
  logic        rd_take;
  logic        stat_clr;
  logic        low_now;
  logic        low_rise;

  assign acc      = psel & penable;
  assign sel      = decode_addr(paddr);
  // A write lands only on the edge that completes the transfer.
  assign wr_take  = acc & pwrite & st_r.ack_due;
  // Reads capture and clear on the first access edge and only there, so an
  // event that arrives during the wait state is not wiped out unseen.
  assign rd_take  = acc & ~pwrite & ~st_r.ack_due;
  assign stat_clr = rd_take & sel.status;
  // The second stage alone feeds the flag; the first stage is never looked at.
  assign low_now  = gate_low(st_r.sync2, st_r.thresh);
  assign low_rise = low_now & ~st_r.low;

  // ==========================================================================
  // Next state
  always_comb begin
    st_nxt         = st_r;
    st_nxt.sync1   = supply_below_cmp;
    st_nxt.sync2   = st_r.sync1;
    // Level follows the comparator both ways, no interrupt enable gates it.
    st_nxt.low     = low_now;
    st_nxt.ack_due = acc & ~st_r.ack_due;
    if (wr_take && sel.thresh) begin
      st_nxt.thresh = keep_impl_bits(pwdata[7:0]);
    end
    if (wr_take && sel.mask) begin
      st_nxt.mask = pwdata[1:0];
    end
    if (rd_take) begin
      st_nxt.rdata = read_word(sel, st_r);
    end
    st_nxt.status  = next_status(st_r.status, stat_clr, low_now, low_rise);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // One wait state: read data is registered on the first access edge, so
  // pready is held back until the second access cycle.
  assign pready                 = acc & st_r.ack_due;
  assign pslverr                = 1'b0;
  assign prdata                 = st_r.rdata;
  assign lockout_enable         = enable_field(st_r.thresh);
  assign lockout_threshold_code = code_field(st_r.thresh);
  assign input_low_flag         = st_r.low;
  assign irq                    = irq_level(st_r.status, st_r.mask);

endmodule

// File: tb/iuvl_ctrl_asserts.sv
// Purpose: Port checks for the lockout control block.
// Assumes: One wait state APB.
// Notes:   The flag trails the comparator by three edges.
`timescale 1ns/1ps
module iuvl_ctrl_asserts
  import iuvl_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        supply_below_cmp,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        lockout_enable,
  input wire logic        input_low_flag,
  input wire logic [5:0]  lockout_threshold_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr; psel && penable && pready && pwrite && paddr == IUVL_THRESH_OFF; endsequence
  property p_code; s_wr |=> lockout_threshold_code == $past(pwdata[5:0]); endproperty
  a_code: assert property (p_code) else $error("code");
  property p_en; s_wr |=> lockout_enable == $past(pwdata[7]); endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_b6; pready && !pwrite && paddr == IUVL_THRESH_OFF |-> !prdata[6]; endproperty
  a_b6: assert property (p_b6) else $error("bit6");
  property p_set; (supply_below_cmp && lockout_enable) [*4] |-> input_low_flag; endproperty
  a_set: assert property (p_set) else $error("set");
  property p_clr; (!supply_below_cmp) [*4] |-> !input_low_flag; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_off; !lockout_enable |=> !input_low_flag; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_sync; $rose(input_low_flag) |-> $past(supply_below_cmp, 3); endproperty
  a_sync: assert property (p_sync) else $error("sync");
endmodule
bind iuvl_ctrl iuvl_ctrl_asserts chk_u (
  .core_clk               (core_clk),
  .rst_n                  (rst_n),
  .psel                   (psel),
  .penable                (penable),
  .pwrite                 (pwrite),
  .pready                 (pready),
  .supply_below_cmp       (supply_below_cmp),
  .paddr                  (paddr),
  .pwdata                 (pwdata),
  .prdata                 (prdata),
  .lockout_enable         (lockout_enable),
  .input_low_flag         (input_low_flag),
  .lockout_threshold_code (lockout_threshold_code)
);

// File: tb/iuvl_ctrl_test.sv
// Purpose: Directed APB bench for the lockout control block.
// Assumes: The flag settles within five edges.
// Notes:   Status reads clear, so each is read once.
`timescale 1ns/1ps
module iuvl_ctrl_test;
  import iuvl_pkg::*;
  logic        core_clk         = 1'b0;
  logic        rst_n            = 1'b0;
  logic        psel             = 1'b0;
  logic        penable          = 1'b0;
  logic        pwrite           = 1'b0;
  logic        supply_below_cmp = 1'b0;
  logic [7:0]  paddr            = 8'h00;
  logic [31:0] pwdata           = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] q;
  logic        err_q;
  logic        pready;
  logic        pslverr;
  logic        lockout_enable;
  logic        input_low_flag;
  logic        irq;
  logic [5:0]  lockout_threshold_code;
  int          num_errors       = 0;
  int          cmp_count        = 0;
  always #5 core_clk = ~core_clk;
  iuvl_ctrl dut_u (
    .core_clk               (core_clk),
    .rst_n                  (rst_n),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .pready                 (pready),
    .prdata                 (prdata),
    .pslverr                (pslverr),
    .supply_below_cmp       (supply_below_cmp),
    .lockout_enable         (lockout_enable),
    .lockout_threshold_code (lockout_threshold_code),
    .input_low_flag         (input_low_flag),
    .irq                    (irq)
  );
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chk_pin(input string s, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (int n = 0; n < 20 && pready !== 1'b1; n++) begin
      @(posedge core_clk);
    end
    if (pready !== 1'b1) begin
      num_errors++;
      $display("BAD pready exp 1 got %b", pready);
      finish_test();
    end else begin
      q       = prdata;
      err_q   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic apb_write(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic apb_read(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    apb_read(IUVL_THRESH_OFF);
    chk("thresh_rst", {24'h000000, IUVL_THRESH_RST}, q);
    chk_pin("slverr", 8'h00, {7'h00, err_q});
    apb_write(IUVL_THRESH_OFF, 32'h0000006A);
    apb_read(IUVL_THRESH_OFF);
    chk("thresh_code", 32'h0000002A, q);
    chk_pin("pins_code", 8'h2A, {1'b0, lockout_enable, lockout_threshold_code});
    apb_write(IUVL_THRESH_OFF, 32'hFFFFFFFF);
    apb_read(IUVL_THRESH_OFF);
    chk("thresh_all", 32'h000000BF, q);
    chk_pin("pins_all", 8'h7F, {1'b0, lockout_enable, lockout_threshold_code});
    $display("test regs done");
    supply_below_cmp <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk_pin("masked", 8'h02, {6'h00, input_low_flag, irq});
    apb_write(IUVL_MASK_OFF, 32'h00000003);
    apb_read(IUVL_MASK_OFF);
    chk("mask_rd", 32'h00000003, q);
    chk_pin("set", 8'h03, {6'h00, input_low_flag, irq});
    apb_read(IUVL_STATUS_OFF);
    chk("stat_low", 32'h00000003, q);
    supply_below_cmp <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk_pin("clr", 8'h01, {6'h00, input_low_flag, irq});
    apb_read(IUVL_STATUS_OFF);
    chk("stat_sticky", 32'h00000001, q);
    @(posedge core_clk);
    chk_pin("irq_off", 8'h00, {7'h00, irq});
    $display("test flag done");
    apb_write(IUVL_THRESH_OFF, 32'h0000003F);
    supply_below_cmp <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk_pin("off", 8'h00, {6'h00, input_low_flag, irq});
    apb_read(IUVL_STATUS_OFF);
    chk("stat_off", 32'h00000000, q);
    apb_write(IUVL_THRESH_OFF, 32'h000000BF);
    repeat (5) @(posedge core_clk);
    chk_pin("on", 8'h03, {6'h00, input_low_flag, irq});
    apb_read(8'h0C);
    chk("unmap", 32'h00000000, q);
    $display("test enable done");
    finish_test();
  end
endmodule
